// [hw/tcit_top.sv]
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// - three independent 16-bit binary or decimal counters
// - one shared timer clock drives all counters
// - first counter output feeds interrupt line zero
// - only third gate external; others held enabled
// - load or decrement on timer clock fall
// - loaded zero counts as full range
// - rate/square reload at end; others wrap
// - bytes collect in input latches, then load
// - software programs each counter before use
// - counters at 40h-42h, control word at 43h
// - control bit 0 selects decimal format
// - bits 1-3 give mode; latch ignores them
// - bits 7-6 counter, bits 5-4 command
// - new count accepted anytime in programmed format
// - latch freezes count until read or reprogram
// - repeated latch before read is ignored
// - read-back bits 1-3 select counters
// - read-back bit 4 low captures status
// - read-back bit 5 low captures count
// - status read first, then count bytes
// - status is output, null, rw, mode, format
// - null set on writes, cleared on load
module tcit_top
  import tcit_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // Avalon-MM slave
  input  wire tcit_pkg::tcit_avs_req_s avs_req,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // Timer pins
  input  wire logic                    timer_clock_pin,
  input  wire logic                    third_gate_input,
  // Counter outputs
  output logic                         irq_line_zero,
  output logic                         counter_one_out,
  output logic                         counter_two_out
);

  import tcit_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tick;
  logic third_gate_input_lvl;
  logic third_gate_input_rise;

  tcit_sync u_clk_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (timer_clock_pin),
    .level    (),
    .rise     (),
    .fall     (tick)
  );

  tcit_sync u_gate_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (third_gate_input),
    .level    (third_gate_input_lvl),
    .rise     (third_gate_input_rise),
    .fall     ()
  );

  wire logic [NUM_CH-1:0] gate_lvl  = {third_gate_input_lvl, 2'b11};
  wire logic [NUM_CH-1:0] gate_rise = {third_gate_input_rise, 2'b00};

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the access edge
  // ----------------------------------------------------------------
  wire logic       req    = avs_req.read || avs_req.write;
  wire logic       acc    = req && !avs_waitrequest;
  wire logic       rd_acc = acc && avs_req.read;
  wire logic       wr_acc = acc && avs_req.write && avs_req.byteenable[0];
  wire logic [6:0] widx   = avs_req.address[ADDR_W-1:2];
  wire logic       align  = avs_req.address[1:0] == 2'b00;
  wire logic [7:0] wdat   = avs_req.writedata[7:0];

  // address decode of counters and control word
  wire logic       hit_ctrl = align && (widx == IDX_CTRL);
  wire logic [NUM_CH-1:0] hit_cnt;
  assign hit_cnt[0] = align && (widx == IDX_CNT0);
  assign hit_cnt[1] = align && (widx == IDX_CNT1);
  assign hit_cnt[2] = align && (widx == IDX_CNT2);

  wire logic       cw_wr  = wr_acc && hit_ctrl;
  wire logic [1:0] cw_sel = wdat[CW_SEL_L +: 2];
  wire logic [1:0] cw_rw  = wdat[CW_RW_L +: 2];

  logic [7:0] rd_byte [NUM_CH];
  logic [7:0] sel_byte;

  // Control word is write-only; unmapped reads return zero
  always_comb begin
    sel_byte = 8'h00;
    for (int k = 0; k < NUM_CH; k++) begin
      if (hit_cnt[k]) begin
        sel_byte = rd_byte[k];
      end
    end
  end

  // Waitrequest drops for one cycle per request; data is ready then
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, sel_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter channels
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] out_w;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    tcit_ctrl_s       ctrl;
    tcit_mode_e       mode;
    tcit_byte_e       wptr;
    tcit_byte_e       rptr;
    logic [7:0]       low_input_latch;
    logic [7:0]       high_input_latch;
    logic [CNT_W-1:0] ce;
    logic [CNT_W-1:0] olatch;
    logic [7:0]       status;
    logic             out;
    logic             null_cnt;
    logic             load_pend;
    logic             have_cnt;
    logic             loaded;
    logic             cnt_lat;
    logic             sts_lat;
    logic             trig;
    logic [CNT_W-1:0] dec1;
    logic [CNT_W-1:0] dec2;
    logic [CNT_W-1:0] next_ce;
    logic             next_out;
    logic             load_ce;

    wire logic gate = gate_lvl[i];
    wire logic [CNT_W-1:0] init = {high_input_latch, low_input_latch};

    // Command decode for this channel
    wire logic me     = cw_sel == 2'(i);
    wire logic prog   = cw_wr && me && (cw_rw != RW_LATCH);
    wire logic rb     = cw_wr && (cw_sel == SEL_RDBK) && wdat[RB_SEL_L + i];
    wire logic lat_c  = cw_wr && me && (cw_rw == RW_LATCH);
    // count capture when bit 5 is low
    wire logic rb_cnt = rb && !wdat[RB_COUNT];
    // status capture when bit 4 is low
    wire logic rb_sts = rb && !wdat[RB_STATUS];
    wire logic cnt_wr = wr_acc && hit_cnt[i];
    wire logic cnt_rd = rd_acc && hit_cnt[i];

    // any byte completing the programmed format
    wire logic done_wr = cnt_wr && ((ctrl.rw != RW_BOTH) ||
                                    (wptr == BYTE_HIGH));
    wire logic rd_high = (ctrl.rw == RW_HIGH) ||
                         ((ctrl.rw == RW_BOTH) && (rptr == BYTE_HIGH));
    wire logic [CNT_W-1:0] rd_val = cnt_lat ? olatch : ce;

    // status first, then count bytes in format
    assign rd_byte[i] = sts_lat ? status :
                        rd_high ? rd_val[15:8] : rd_val[7:0];
    assign out_w[i]   = out;

    // zero loads wrap through the full range
    // decimal format steers the down step
    tcit_down_step u_dec1 (
      .value  (ce),
      .bcd    (ctrl.bcd),
      .result (dec1)
    );

    tcit_down_step u_dec2 (
      .value  (dec1),
      .bcd    (ctrl.bcd),
      .result (dec2)
    );

    // Load on pending count, or on trigger for gated modes
    wire logic trig_mode = (mode == M_ONESH) || (mode == M_HWSTRB) ||
                           (mode == M_RATE)  || (mode == M_SQUARE);
    wire logic pend_mode = (mode == M_TERM)  || (mode == M_SWSTRB) ||
                           (((mode == M_RATE) || (mode == M_SQUARE)) &&
                            !loaded);
    wire logic load_now  = (load_pend && pend_mode) ||
                           (trig && have_cnt && trig_mode);

    // Next count and output at each timer clock fall
    always_comb begin
      next_ce  = ce;
      next_out = out;
      load_ce  = 1'b0;
      if (tick && load_now) begin
        // input latches move to the counter in one tick
        next_ce = init;
        load_ce = 1'b1;
        if (mode == M_ONESH) begin
          next_out = 1'b0;
        end else if (trig_mode) begin
          next_out = 1'b1;
        end
      end else if (tick && loaded) begin
        unique case (mode)
          M_TERM: begin
            if (gate) begin
              next_ce = dec1;
              if (dec1 == 16'h0000) begin
                next_out = 1'b1;
              end
            end
          end
          M_ONESH: begin
            next_ce = dec1;
            if (dec1 == 16'h0000) begin
              next_out = 1'b1;
            end
          end
          // rate and square modes reload at the end
          M_RATE: begin
            if (gate && (ce == 16'h0001)) begin
              next_ce  = init;
              load_ce  = 1'b1;
              next_out = 1'b1;
            end else if (gate) begin
              next_ce  = dec1;
              next_out = ce != 16'h0002;
            end
          end
          M_SQUARE: begin
            if (gate && ((ce == 16'h0002) || (ce == 16'h0001))) begin
              next_ce  = init;
              load_ce  = 1'b1;
              next_out = !out;
            end else if (gate) begin
              next_ce = dec2;
            end
          end
          M_SWSTRB: begin
            if (gate) begin
              next_ce  = dec1;
              next_out = dec1 != 16'h0000;
            end
          end
          M_HWSTRB: begin
            next_ce  = dec1;
            next_out = dec1 != 16'h0000;
          end
          default: begin
            next_ce = ce;
          end
        endcase
      end
      // A low gate forces the output high in rate and square modes
      if (((mode == M_RATE) || (mode == M_SQUARE)) && !gate) begin
        next_out = 1'b1;
      end
    end

    // Control register written by a read/write command
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        ctrl <= tcit_ctrl_s'(CTRL_RST[5:0]);
        mode <= M_TERM;
      end else if (prog) begin
        ctrl <= tcit_ctrl_s'(wdat[5:0]);
        // explicit decode of modes 4 and 5
        mode <= tcit_decode_mode(wdat[CW_MODE_L +: 3]);
      end
    end

    // count bytes follow the control word's format
    always_ff @(posedge mclk) begin
      if (!rst_b || prog) begin
        wptr             <= BYTE_LOW;
        low_input_latch  <= 8'h00;
        high_input_latch <= 8'h00;
        have_cnt         <= 1'b0;
      end else if (cnt_wr) begin
        unique case (ctrl.rw)
          RW_LOW: begin
            low_input_latch  <= wdat;
            high_input_latch <= 8'h00;
          end
          RW_HIGH: begin
            low_input_latch  <= 8'h00;
            high_input_latch <= wdat;
          end
          RW_BOTH: begin
            if (wptr == BYTE_LOW) begin
              low_input_latch <= wdat;
            end else begin
              high_input_latch <= wdat;
            end
            wptr <= (wptr == BYTE_LOW) ? BYTE_HIGH : BYTE_LOW;
          end
          default: begin
            wptr <= BYTE_LOW;
          end
        endcase
        have_cnt <= have_cnt || done_wr;
      end
    end

    // Counting element, output level and load bookkeeping
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        ce     <= 16'h0000;
        out    <= 1'b0;
        loaded <= 1'b0;
      end else if (prog) begin
        out    <= tcit_decode_mode(wdat[CW_MODE_L +: 3]) != M_TERM;
        loaded <= 1'b0;
      end else begin
        ce     <= next_ce;
        loaded <= loaded || load_ce;
        out    <= (done_wr && (mode == M_TERM)) ? 1'b0 : next_out;
      end
    end

    // writes set null count and win over a load
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        null_cnt  <= 1'b0;
        load_pend <= 1'b0;
        trig      <= 1'b0;
      end else begin
        null_cnt  <= prog || cnt_wr || (null_cnt && !load_ce);
        load_pend <= !prog && (done_wr || (load_pend && !load_ce));
        trig      <= gate_rise[i] || (trig && !tick);
      end
    end

    // output latch holds until read or reprogram
    // a second latch before the read is ignored
    always_ff @(posedge mclk) begin
      if (!rst_b || prog) begin
        olatch  <= 16'h0000;
        cnt_lat <= 1'b0;
        rptr    <= BYTE_LOW;
      end else if ((lat_c || rb_cnt) && !cnt_lat) begin
        olatch  <= ce;
        cnt_lat <= 1'b1;
      end else if (cnt_rd && !sts_lat) begin
        if (ctrl.rw == RW_BOTH) begin
          rptr    <= (rptr == BYTE_LOW) ? BYTE_HIGH : BYTE_LOW;
          cnt_lat <= cnt_lat && (rptr == BYTE_LOW);
        end else begin
          cnt_lat <= 1'b0;
        end
      end
    end

    // status layout is out, null, then control bits
    always_ff @(posedge mclk) begin
      if (!rst_b || prog) begin
        status  <= 8'h00;
        sts_lat <= 1'b0;
      end else if (rb_sts && !sts_lat) begin
        status  <= {out, null_cnt, ctrl};
        sts_lat <= 1'b1;
      end else if (cnt_rd) begin
        sts_lat <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // first counter drives interrupt line zero
  assign irq_line_zero   = out_w[0];
  assign counter_one_out = out_w[1];
  assign counter_two_out = out_w[2];

endmodule : tcit_top

// [shared/tcit_pkg.sv]
package tcit_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are indices, byte address = 4*idx)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 9;
  localparam logic [6:0]  IDX_CNT0  = 7'h40;
  localparam logic [6:0]  IDX_CNT1  = 7'h41;
  localparam logic [6:0]  IDX_CNT2  = 7'h42;
  localparam logic [6:0]  IDX_CTRL  = 7'h43;
  localparam int unsigned NUM_CH    = 3;
  localparam int unsigned CNT_W     = 16;

  // ----------------------------------------------------------------
  // Control word and status byte fields
  // ----------------------------------------------------------------
  localparam int unsigned CW_BCD    = 0;
  localparam int unsigned CW_MODE_L = 1;
  localparam int unsigned CW_RW_L   = 4;
  localparam int unsigned CW_SEL_L  = 6;
  localparam int unsigned RB_SEL_L  = 1;
  localparam int unsigned RB_STATUS = 4;
  localparam int unsigned RB_COUNT  = 5;
  localparam logic [1:0]  RW_LATCH  = 2'h0;
  localparam logic [1:0]  RW_LOW    = 2'h1;
  localparam logic [1:0]  RW_HIGH   = 2'h2;
  localparam logic [1:0]  RW_BOTH   = 2'h3;
  localparam logic [1:0]  SEL_RDBK  = 2'h3;
  localparam logic [3:0]  DIGIT_MAX = 4'h9;
  localparam logic [7:0]  CTRL_RST  = 8'h00;

  // Operating modes after decoding the three mode bits
  typedef enum logic [2:0] {
    M_TERM   = 3'b000,
    M_ONESH  = 3'b001,
    M_RATE   = 3'b010,
    M_SQUARE = 3'b011,
    M_SWSTRB = 3'b100,
    M_HWSTRB = 3'b101
  } tcit_mode_e;

  // Byte pointer of the low/high transfer sequence
  typedef enum logic {
    BYTE_LOW  = 1'b0,
    BYTE_HIGH = 1'b1
  } tcit_byte_e;

  // Stored control setting, laid out as status bits 5..0
  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode_bits;
    logic       bcd;
  } tcit_ctrl_s;

  // Avalon-MM request side
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } tcit_avs_req_s;

  function automatic tcit_mode_e tcit_decode_mode(input logic [2:0] b);
    if (b[1])
      return b[0] ? M_SQUARE : M_RATE;
    else if (b[2])
      return b[0] ? M_HWSTRB : M_SWSTRB;
    else
      return b[0] ? M_ONESH : M_TERM;
  endfunction : tcit_decode_mode

endpackage : tcit_pkg

// [hw/tcit_sync.sv]
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module tcit_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Pin and clean result
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic [2:0] fill;
  logic       seeded;
  wire logic  agree = s2 == s3;

  // Stage 1 feeds stage 2 only, to keep metastability contained
  // The first agreed level after reset is taken without an edge, so an
  // idle-high pin is not mistaken for a rise when reset lets go
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1     <= 1'b0;
      s2     <= 1'b0;
      s3     <= 1'b0;
      fill   <= 3'h0;
      seeded <= 1'b0;
      level  <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      s1     <= async_in;
      s2     <= s1;
      s3     <= s2;
      fill   <= {fill[1:0], 1'b1};
      rise   <= seeded && agree && s3 && !level;
      fall   <= seeded && agree && !s3 && level;
      if (agree && (seeded || fill[2])) begin
        level  <= s3;
        seeded <= 1'b1;
      end
    end
  end

endmodule : tcit_sync

// [hw/tcit_down_step.sv]
`timescale 1ns/1ps
// One down step of a 16-bit count, binary or four decimal digits
module tcit_down_step
  import tcit_pkg::*;
(
  // Operand and format
  input  wire logic [CNT_W-1:0] value,
  input  wire logic             bcd,
  // Decremented value, wrapping through zero
  output logic [CNT_W-1:0]      result
);

  logic [4:0]       borrow;
  logic [CNT_W-1:0] bcd_res;

  assign borrow[0] = 1'b1;

  // Digit borrow chain; 0000 wraps to 9999 by itself
  for (genvar d = 0; d < 4; d++) begin : g_digit
    wire logic [3:0] dig = value[4*d +: 4];
    assign bcd_res[4*d +: 4] = !borrow[d] ? dig :
                               (dig == 4'h0) ? DIGIT_MAX : dig - 4'h1;
    assign borrow[d+1] = borrow[d] && (dig == 4'h0);
  end

  // Binary wraps to ffff the same way
  assign result = bcd ? bcd_res : value - 16'h0001;

endmodule : tcit_down_step

// [verif/tcit_checker.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus and counter output checker
// ----------------------------------------------------------------
module tcit_checker
  import tcit_pkg::*;
(
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_b,
  // Avalon-MM slave
  input wire tcit_pkg::tcit_avs_req_s avs_req,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // Timer pins
  input wire logic                    timer_clock_pin,
  input wire logic                    third_gate_input,
  // Counter outputs
  input wire logic                    irq_line_zero,
  input wire logic                    counter_one_out,
  input wire logic                    counter_two_out
);
  import tcit_pkg::*;

  logic [3:0] quiet;
  logic       pin_q;
  logic       gate_q;

  // Request decode seen from the bus side
  wire       req_any = avs_req.read | avs_req.write;
  wire [6:0] idx     = avs_req.address[8:2];
  wire       mapped  = (idx >= IDX_CNT0) && (idx <= IDX_CTRL);
  // Any pin edge or bus access may move an output a few cycles later
  wire       cause   = req_any | (timer_clock_pin != pin_q)
                     | (third_gate_input != gate_q);

  // Quiet span counter; saturates so it never wraps back to zero
  always_ff @(posedge mclk) begin
    pin_q  <= timer_clock_pin;
    gate_q <= third_gate_input;
    if (!rst_b || cause)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_wait_one_low: assert property (
    $fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_has_req: assert property (
    !avs_waitrequest |-> $past(req_any))
    else $error("acknowledge without a request");
  a_req_gets_ack: assert property (
    req_any && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not acknowledged after one wait cycle");
  a_data_byte_wide: assert property (
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ctrl_reads_zero: assert property (
    avs_req.read && !avs_waitrequest && idx == IDX_CTRL
      |-> avs_readdata == 32'h0)
    else $error("control word readable");
  a_unmapped_zero: assert property (
    avs_req.read && !avs_waitrequest && !mapped
      |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_holds: assert property (
    !req_any |=> $stable(avs_readdata))
    else $error("read data changed without a request");
  a_out_need_cause: assert property (
    quiet >= 4'h8 |->
      $stable({irq_line_zero, counter_one_out, counter_two_out}))
    else $error("counter output moved without tick or access");
endmodule : tcit_checker

bind tcit_top tcit_checker tcit_checker_i (
  .mclk            (mclk),
  .rst_b           (rst_b),
  .avs_req         (avs_req),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .timer_clock_pin (timer_clock_pin),
  .third_gate_input(third_gate_input),
  .irq_line_zero   (irq_line_zero),
  .counter_one_out (counter_one_out),
  .counter_two_out (counter_two_out)
);

// [verif/tcit_bench.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register level bench
// ----------------------------------------------------------------
module tcit_bench;
  import tcit_pkg::*;

  logic          mclk;
  logic          rst_b;
  tcit_avs_req_s req;
  logic [31:0]   rdata;
  logic          wreq;
  logic          tpin;
  logic          gate;
  logic          irq0;
  logic          out1;
  logic          out2;
  int            n_fail;
  int            checked;
  logic [7:0]    rb;

  tcit_top tcit_top_i (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .avs_req         (req),
    .avs_readdata    (rdata),
    .avs_waitrequest (wreq),
    .timer_clock_pin (tpin),
    .third_gate_input(gate),
    .irq_line_zero   (irq0),
    .counter_one_out (out1),
    .counter_two_out (out2)
  );

  always #5 mclk = ~mclk;

  // One Avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge mclk);
    req.read       <= !wr;
    req.write      <= wr;
    req.address    <= {a, 2'b00};
    req.writedata  <= {24'h0, d};
    req.byteenable <= 4'hf;
    n = 0;
    @(posedge mclk);
    while (wreq !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] t=%0t no ack got %h exp %h", $time, wreq, 1'b0);
    end
    q = rdata[7:0];
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp8

  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t pin got %h exp %h", $time, g, e);
    end
  endtask : cmp1

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp8(q, e);
  endtask : rdc

  // Timer pin pulses, each level held well beyond the synchroniser
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk);
      tpin <= 1'b0;
      repeat (4) @(posedge mclk);
      tpin <= 1'b1;
      repeat (5) @(posedge mclk);
    end
  endtask : tick

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("[ERR] t=%0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    req = '0;
    tpin = 1'b1;
    gate = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    // Counter 2 rate generator, count 3, status and count read-back
    wr(IDX_CTRL, 8'hb4);
    wr(IDX_CNT2, 8'h03);
    wr(IDX_CNT2, 8'h00);
    wr(IDX_CTRL, 8'he8);
    rdc(IDX_CNT2, 8'hf4);
    tick(1);
    wr(IDX_CTRL, 8'hc8);
    rdc(IDX_CNT2, 8'hb4);
    rdc(IDX_CNT2, 8'h03);
    rdc(IDX_CNT2, 8'h00);
    tick(2);
    cmp1(out2, 1'b0);
    tick(1);
    cmp1(out2, 1'b1);
    rdc(IDX_CNT2, 8'h03);
    rdc(IDX_CNT2, 8'h00);
    tick(2);
    gate <= 1'b0;
    repeat (12) @(posedge mclk);
    cmp1(out2, 1'b1);
    gate <= 1'b1;
    $display("test rate_gen done");
    // Counter 1 mode 0: latch, repeated latch, new count, wrap
    wr(IDX_CTRL, 8'h70);
    wr(IDX_CNT1, 8'h05);
    wr(IDX_CNT1, 8'h00);
    cmp1(out1, 1'b0);
    tick(1);
    wr(IDX_CTRL, 8'h40);
    tick(2);
    wr(IDX_CTRL, 8'h40);
    rdc(IDX_CNT1, 8'h05);
    rdc(IDX_CNT1, 8'h00);
    rdc(IDX_CNT1, 8'h03);
    rdc(IDX_CNT1, 8'h00);
    wr(IDX_CNT1, 8'h02);
    wr(IDX_CNT1, 8'h00);
    tick(1);
    rdc(IDX_CNT1, 8'h02);
    rdc(IDX_CNT1, 8'h00);
    tick(2);
    cmp1(out1, 1'b1);
    tick(1);
    rdc(IDX_CNT1, 8'hff);
    rdc(IDX_CNT1, 8'hff);
    $display("test latch done");
    // Counter 0: zero load in decimal and in binary, low byte only
    wr(IDX_CTRL, 8'h31);
    wr(IDX_CNT0, 8'h00);
    wr(IDX_CNT0, 8'h00);
    cmp1(irq0, 1'b0);
    tick(2);
    rdc(IDX_CNT0, 8'h99);
    rdc(IDX_CNT0, 8'h99);
    wr(IDX_CTRL, 8'h10);
    wr(IDX_CNT0, 8'h00);
    tick(2);
    rdc(IDX_CNT0, 8'hff);
    wr(IDX_CTRL, 8'he2);
    rdc(IDX_CNT0, 8'h10);
    $display("test zero_load done");
    // Counter 0 software strobe, count 2: one low tick after N+1 ticks
    wr(IDX_CTRL, 8'h18);
    wr(IDX_CNT0, 8'h02);
    tick(2);
    cmp1(irq0, 1'b1);
    tick(1);
    cmp1(irq0, 1'b0);
    tick(1);
    cmp1(irq0, 1'b1);
    $display("test strobe done");
    // Every format and mode code echoed in the status byte
    for (int i = 1; i < 4; i++) begin
      for (int m = 0; m < 8; m++) begin
        wr(IDX_CTRL, {2'h1, i[1:0], m[2:0], i[0]});
        wr(IDX_CTRL, 8'he4);
        bus(1'b0, IDX_CNT1, 8'h00, rb);
        // Mode 0 drives the output low on a control write, others high
        cmp8(rb, {m != 0, 1'b1, i[1:0], m[2:0], i[0]});
      end
    end
    $display("test mode_codes done");
    // Unmapped place and write-only control word
    wr(7'h44, 8'h5a);
    rdc(7'h44, 8'h00);
    rdc(IDX_CTRL, 8'h00);
    $display("test decode done");
    end_sim();
  end
endmodule : tcit_bench
